// ### rtl/gpio_sense_pkg.sv
`default_nettype none
package gpio_sense_pkg;
  localparam int unsigned NUM_PINS = 32;
  localparam int unsigned ADDR_W = 12;

  localparam logic [11:0] OFF_OUT = 12'h504;
  localparam logic [11:0] OFF_OUTSET = 12'h508;
  localparam logic [11:0] OFF_OUTCLR = 12'h50C;
  localparam logic [11:0] OFF_IN = 12'h510;
  localparam logic [11:0] OFF_DIR = 12'h514;
  localparam logic [11:0] OFF_DIRSET = 12'h518;
  localparam logic [11:0] OFF_DIRCLR = 12'h51C;
  localparam logic [11:0] OFF_LATCH = 12'h520;
  localparam logic [11:0] OFF_DETECT_SRC = 12'h524;
  localparam logic [11:0] OFF_CFG_BASE = 12'h700;
  localparam logic [4:0] CFG_REGION = 5'h0E;

  // Pin configuration word layout
  localparam int unsigned CFG_DIR_BIT = 0;
  localparam int unsigned CFG_DISC_BIT = 1;
  localparam int unsigned CFG_PULL_LSB = 2;
  localparam int unsigned CFG_ANA_BIT = 4;
  localparam int unsigned CFG_DRIVE_LSB = 8;
  localparam int unsigned CFG_SENSE_LSB = 16;
  localparam logic [31:0] CFG_WMASK = 32'h0003071F;
  localparam logic [31:0] CFG_RESET = 32'h00000002;

  localparam logic [1:0] PULL_DOWN = 2'h1;
  localparam logic [1:0] PULL_UP = 2'h3;
  localparam logic [1:0] SENSE_OFF = 2'h0;
  localparam logic [1:0] SENSE_HIGH = 2'h2;
  localparam logic [1:0] SENSE_LOW = 2'h3;

  localparam logic [31:0] WORD_RESET = 32'h00000000;
  localparam logic DETECT_SRC_RESET = 1'b0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Override bundle from another peripheral, one bit per pin
  typedef struct packed {
    logic [31:0] en;
    logic [31:0] out;
    logic [31:0] drive_en;
    logic [31:0] input_en;
  } pin_override_s;

  // Pad controls towards the pins
  typedef struct packed {
    logic [31:0] out;
    logic [31:0] oe_n;
    logic [31:0] input_en;
    logic [31:0] pull_up;
    logic [31:0] pull_dn;
    logic [31:0] analog_en;
    logic [31:0][2:0] drive;
  } pad_ctrl_s;
endpackage
`default_nettype wire

// ### rtl/gpio_sense_latch_detect.sv
// What this block does
// - Port has 32 pins, indices 0 to 31, each with its own configuration word.
// - Config word sets direction, drive, pulls, sensing, input disconnect, analog input.
// - Sense field selects high level, low level, or sensing off.
// - Each pin drives its own detect high while the chosen sense level is present.
// - By default the port detect is the OR of all pin detects.
// - Sensing and the pin OR port detect keep working in running and deepest power-off states; in power-off a latched port detect holds the latch.
// - A sense condition already met when enabled raises the pin detect at once.
// - Port sense event fires only when port detect rises from low.
// - Pin x detect going high sets bit x of the latch word.
// - Clearing a latch bit has no effect while its pin detect is still high.
// - Latch bits clear only by writing one; detect falling leaves them alone.
// - Latched detect is high while any latch bit is one, low when all clear.
// - Bits still set after a clear give a fresh rising edge on latched detect.
// - Latch word is readable at any time, whatever the detect source.
// - Detect source picks pin OR or latched detect as port detect.
// - Input word bit and sensing are valid only while the input buffer is connected.
// - Each input buffer can be disconnected through the configuration word.
// - Peripherals can override pin output, direction and input buffer connection and read its input; pulls, drive and analog stay with the config word.
// - Latch word sits at offset 0x520, one bit per pin.
// - Detect source setting sits at offset 0x524.
// - Configuration words start at 0x700, one word per pin, stride four bytes.
`default_nettype none
module gpio_sense_latch_detect
  import gpio_sense_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] pin_in,
  output pad_ctrl_s pad_ctrl,
  input wire pin_override_s pin_override,
  output logic [31:0] periph_pin_in,
  input wire logic power_off,
  output logic [31:0] pin_detect,
  output logic port_detect,
  output logic latched_detect,
  output logic port_sense_event
);

  typedef struct packed {
    logic [31:0] out;
    logic [31:0] dir;
    logic [31:0][31:0] cfg;
    logic [31:0] latch;
    logic detect_src;
    logic [31:0] sync1;
    logic [31:0] sync2;
    logic port_det_prev;
    logic port_event;
    logic relatch_gap;
    logic aw_ok;
    logic w_ok;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_s;

  state_s st_q;
  state_s st_d;

  logic [31:0] in_connected;
  logic [31:0] det_sync;
  logic [31:0] det_raw;
  logic [31:0] in_word;
  logic any_latch;
  logic port_det_run;

  function automatic logic [31:0] strb_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = 32'h00000000;
    for (int b = 0; b < 4; b++)
    begin
      m[8*b +: 8] = {8{strb[b]}};
    end
    return m;
  endfunction

  function automatic logic sense_hit(input logic [1:0] sense, input logic level, input logic conn);
    logic hit;
    hit = 1'b0;
    if (conn)
    begin
      hit = ((sense == SENSE_HIGH) && level) || ((sense == SENSE_LOW) && !level);
    end
    return hit;
  endfunction

  // Per-pin pad control, input gating and detect
  for (genvar i = 0; i < NUM_PINS; i++)
  begin : g_pin
    logic ovr;
    logic [31:0] c;
    assign ovr = pin_override.en[i];
    assign c = st_q.cfg[i];
    // Buffer connected by software or by an overriding peripheral
    assign in_connected[i] = ovr ? pin_override.input_en[i] : !c[CFG_DISC_BIT];
    assign pad_ctrl.input_en[i] = in_connected[i];
    assign pad_ctrl.out[i] = ovr ? pin_override.out[i] : st_q.out[i];
    assign pad_ctrl.oe_n[i] = ovr ? !pin_override.drive_en[i] : !st_q.dir[i];
    assign pad_ctrl.pull_up[i] = (c[CFG_PULL_LSB +: 2] == PULL_UP);
    assign pad_ctrl.pull_dn[i] = (c[CFG_PULL_LSB +: 2] == PULL_DOWN);
    assign pad_ctrl.analog_en[i] = c[CFG_ANA_BIT];
    assign pad_ctrl.drive[i] = c[CFG_DRIVE_LSB +: 3];
    assign in_word[i] = in_connected[i] & st_q.sync2[i];
    // Level compare is combinational, so enabling on a matching level detects at once
    assign det_sync[i] = sense_hit(c[CFG_SENSE_LSB +: 2], st_q.sync2[i], in_connected[i]);
    // Clock-free path for the powered-off state, where no edge arrives
    assign det_raw[i] = sense_hit(c[CFG_SENSE_LSB +: 2], pin_in[i], in_connected[i]);
  end

  assign periph_pin_in = in_word;
  assign pin_detect = power_off ? det_raw : det_sync;

  // One-cycle dip after a clear that leaves bits set gives a fresh rising edge
  assign any_latch = |st_q.latch;
  assign latched_detect = any_latch & !st_q.relatch_gap;
  assign port_det_run = st_q.detect_src ? latched_detect : |det_sync;
  // Latch cannot move without a clock; in power-off the raw OR or the held latch feeds out
  assign port_detect = power_off ? (st_q.detect_src ? any_latch : |det_raw) : port_det_run;
  assign port_sense_event = st_q.port_event;

  assign s_axi_awready = !st_q.aw_ok && !st_q.bvalid;
  assign s_axi_wready = !st_q.w_ok && !st_q.bvalid;
  assign s_axi_bvalid = st_q.bvalid;
  assign s_axi_bresp = st_q.bresp;
  assign s_axi_arready = !st_q.rvalid;
  assign s_axi_rvalid = st_q.rvalid;
  assign s_axi_rdata = st_q.rdata;
  assign s_axi_rresp = st_q.rresp;

  always_comb
  begin
    logic [ADDR_W-1:0] wa;
    logic [ADDR_W-1:0] ra;
    logic [31:0] wd;
    logic [31:0] wm;
    logic [31:0] clr_mask;
    logic do_write;
    logic hit_w;
    logic hit_r;
    logic [31:0] rd;
    logic [4:0] widx;
    logic [4:0] ridx;
    wa = s_axi_awvalid && s_axi_awready ? s_axi_awaddr : st_q.awaddr;
    wd = s_axi_wvalid && s_axi_wready ? s_axi_wdata : st_q.wdata;
    wm = strb_mask(s_axi_wvalid && s_axi_wready ? s_axi_wstrb : st_q.wstrb);
    ra = s_axi_araddr;
    clr_mask = 32'h00000000;
    hit_w = 1'b1;
    hit_r = 1'b1;
    do_write = 1'b0;
    rd = 32'h00000000;
    widx = wa[6:2];
    ridx = ra[6:2];
    st_d = st_q;

    st_d.sync1 = pin_in;
    st_d.sync2 = st_q.sync1;

    if (s_axi_awvalid && s_axi_awready)
    begin
      st_d.aw_ok = 1'b1;
      st_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      st_d.w_ok = 1'b1;
      st_d.wdata = s_axi_wdata;
      st_d.wstrb = s_axi_wstrb;
    end
    do_write = st_d.aw_ok && st_d.w_ok;

    if (do_write)
    begin
      if (wa == OFF_OUT)
      begin
        st_d.out = (st_q.out & ~wm) | (wd & wm);
      end
      else if (wa == OFF_OUTSET)
      begin
        st_d.out = st_q.out | (wd & wm);
      end
      else if (wa == OFF_OUTCLR)
      begin
        st_d.out = st_q.out & ~(wd & wm);
      end
      else if (wa == OFF_DIR)
      begin
        st_d.dir = (st_q.dir & ~wm) | (wd & wm);
      end
      else if (wa == OFF_DIRSET)
      begin
        st_d.dir = st_q.dir | (wd & wm);
      end
      else if (wa == OFF_DIRCLR)
      begin
        st_d.dir = st_q.dir & ~(wd & wm);
      end
      else if (wa == OFF_LATCH)
      begin
        clr_mask = wd & wm;
      end
      else if (wa == OFF_DETECT_SRC)
      begin
        if (wm[0])
        begin
          st_d.detect_src = wd[0];
        end
      end
      else if (wa == OFF_IN)
      begin
        hit_w = 1'b1;
      end
      else if (wa[11:7] == CFG_REGION && wa[1:0] == 2'h0)
      begin
        st_d.cfg[widx] = (st_q.cfg[widx] & ~(wm & CFG_WMASK)) | (wd & wm & CFG_WMASK);
        // Direction bit mirrors into the direction word
        if (wm[CFG_DIR_BIT])
        begin
          st_d.dir[widx] = wd[CFG_DIR_BIT];
        end
      end
      else
      begin
        hit_w = 1'b0;
      end
      st_d.aw_ok = 1'b0;
      st_d.w_ok = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp = hit_w ? RESP_OKAY : RESP_SLVERR;
    end
    else if (st_q.bvalid && s_axi_bready)
    begin
      st_d.bvalid = 1'b0;
    end

    // Every direction write path keeps config bit and direction word as one state
    if (do_write)
    begin
      for (int p = 0; p < NUM_PINS; p++)
      begin
        st_d.cfg[p][CFG_DIR_BIT] = st_d.dir[p];
      end
    end

    // A detect that is high wins over a clear in the same cycle
    st_d.latch = (st_q.latch & ~clr_mask) | det_sync;
    st_d.relatch_gap = (|clr_mask) && (|st_d.latch);

    st_d.port_det_prev = port_det_run;
    st_d.port_event = port_det_run && !st_q.port_det_prev;

    if (s_axi_arvalid && s_axi_arready)
    begin
      if (ra == OFF_OUT || ra == OFF_OUTSET || ra == OFF_OUTCLR)
      begin
        rd = st_q.out;
      end
      else if (ra == OFF_IN)
      begin
        rd = in_word;
      end
      else if (ra == OFF_DIR || ra == OFF_DIRSET || ra == OFF_DIRCLR)
      begin
        rd = st_q.dir;
      end
      else if (ra == OFF_LATCH)
      begin
        rd = st_q.latch;
      end
      else if (ra == OFF_DETECT_SRC)
      begin
        rd = {31'h00000000, st_q.detect_src};
      end
      else if (ra[11:7] == CFG_REGION && ra[1:0] == 2'h0)
      begin
        rd = st_q.cfg[ridx];
      end
      else
      begin
        hit_r = 1'b0;
      end
      st_d.rvalid = 1'b1;
      st_d.rdata = rd;
      st_d.rresp = hit_r ? RESP_OKAY : RESP_SLVERR;
    end
    else if (st_q.rvalid && s_axi_rready)
    begin
      st_d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q <= '0;
      st_q.out <= WORD_RESET;
      st_q.dir <= WORD_RESET;
      st_q.latch <= WORD_RESET;
      st_q.detect_src <= DETECT_SRC_RESET;
      for (int p = 0; p < NUM_PINS; p++)
      begin
        st_q.cfg[p] <= CFG_RESET;
      end
    end
    else
    begin
      st_q <= st_d;
    end
  end

endmodule
`default_nettype wire

// ### verif/gpio_sense_latch_detect_monitor.sv
`default_nettype none
module gpio_sense_latch_detect_monitor
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic power_off,
  input wire logic [31:0] pin_detect,
  input wire logic port_detect,
  input wire logic latched_detect,
  input wire logic port_sense_event
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  a_write_answer: assert property ($rose(s_axi_bvalid) |-> $past(s_axi_awvalid && s_axi_awready) ||
    $past(s_axi_wvalid && s_axi_wready))
    else $error("write response without request");
  a_port_source: assert property (port_detect |-> (|pin_detect) || latched_detect)
    else $error("port detect without source");
  a_event_rise: assert property ($rose(port_detect) && !power_off && !$past(power_off) |=> port_sense_event)
    else $error("no event on port rise");
  a_event_cause: assert property (port_sense_event && !$past(power_off) && !$past(power_off, 2) |->
    $past(port_detect) && !$past(port_detect, 2))
    else $error("event without port rise");
  a_latch_follows: assert property ($rose(|pin_detect) && !power_off |-> ##[1:2] latched_detect)
    else $error("latch not set");
  a_ldet_fall: assert property ($fell(latched_detect) |-> s_axi_bvalid)
    else $error("latched detect fell without clear");
  cover property (port_sense_event);
  cover property ($fell(latched_detect) ##1 latched_detect);
  cover property (power_off && port_detect);
endmodule
bind gpio_sense_latch_detect gpio_sense_latch_detect_monitor u_gpio_sense_latch_detect_monitor (.*);
`default_nettype wire

// ### verif/pin_model.sv
`default_nettype none
module pin_model
  import gpio_sense_pkg::*;
(
  input wire logic aclk,
  input wire logic [31:0] ext_en,
  input wire logic [31:0] ext_lvl,
  input wire pad_ctrl_s pad_ctrl,
  output logic [31:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Undriven pin toggles so a stale level cannot pass for a real one
  logic [31:0] float_q = 32'h0;
  always @(posedge aclk)
    float_q <= ~float_q;
  always_comb
    for (int i = 0; i < 32; i++)
      pin_in[i] = !pad_ctrl.oe_n[i] ? pad_ctrl.out[i] : ext_en[i] ? ext_lvl[i] :
        pad_ctrl.pull_up[i] ? 1'b1 : pad_ctrl.pull_dn[i] ? 1'b0 : float_q[i];
endmodule
`default_nettype wire

// ### verif/gpio_sense_latch_detect_tb.sv
`default_nettype none
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin mismatches++; $display("ERROR %s exp %0h got %0h", n, e, a); end end
module gpio_sense_latch_detect_tb import gpio_sense_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h0;
  logic [11:0] s_axi_araddr = 12'h0;
  logic [2:0] s_axi_awprot = 3'h0;
  logic [2:0] s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1;
  logic s_axi_rready = 1'b1;
  logic power_off = 1'b0;
  pin_override_s pin_override = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, pin_in, periph_pin_in, pin_detect;
  logic port_detect, latched_detect, port_sense_event;
  pad_ctrl_s pad_ctrl;
  logic [31:0] ext_en = 32'h0;
  logic [31:0] ext_lvl = 32'h0;
  logic [31:0] m_latch = 32'h0;
  logic ld_b;
  int seed = 32'h1423;
  int mismatches = 0;
  int n_checks = 0;
  gpio_sense_latch_detect u_gpio_sense_latch_detect (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in, .pad_ctrl, .pin_override, .periph_pin_in, .power_off,
    .pin_detect, .port_detect, .latched_detect, .port_sense_event);
  pin_model u_pin_model (.aclk, .ext_en, .ext_lvl, .pad_ctrl, .pin_in);
  always #5 aclk = ~aclk;
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic bound(input int n);
    if (n >= 50)
    begin
      mismatches++;
      tally_and_finish();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1 && n < 50);
    bound(n);
    ld_b = latched_detect;
    `CHK("bresp", r, s_axi_bresp)
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1 && n < 50);
    bound(n);
    `CHK("rdata", e, s_axi_rdata)
    `CHK("rresp", r, s_axi_rresp)
  endtask
  initial
  begin
    int p;
    int k;
    logic [31:0] bit_p;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (k = 0; k < NUM_PINS; k++)
      rd(OFF_CFG_BASE + 12'(4 * k), CFG_RESET, RESP_OKAY);
    rd(OFF_LATCH, WORD_RESET, RESP_OKAY);
    rd(OFF_DETECT_SRC, 32'h0, RESP_OKAY);
    wr(12'h600, 32'hFFFFFFFF, RESP_SLVERR);
    rd(12'h600, 32'h0, RESP_SLVERR);
    wr(OFF_CFG_BASE + 12'h07C, 32'hFFFFFFFF, RESP_OKAY);
    `CHK("pull_up", 1'b1, pad_ctrl.pull_up[31])
    `CHK("pull_dn", 1'b0, pad_ctrl.pull_dn[31])
    `CHK("drive", 3'h7, pad_ctrl.drive[31])
    `CHK("analog", 1'b1, pad_ctrl.analog_en[31])
    `CHK("in_en", 1'b0, pad_ctrl.input_en[31])
    `CHK("oe_n31", 1'b0, pad_ctrl.oe_n[31])
    rd(OFF_CFG_BASE + 12'h07C, CFG_WMASK, RESP_OKAY);
    rd(OFF_DIR, 32'h80000000, RESP_OKAY);
    wr(OFF_CFG_BASE + 12'h07C, CFG_RESET, RESP_OKAY);
    wr(OFF_OUTSET, 32'h00000005, RESP_OKAY);
    wr(OFF_OUTCLR, 32'h00000004, RESP_OKAY);
    rd(OFF_OUT, 32'h00000001, RESP_OKAY);
    wr(OFF_DIRSET, 32'h00000001, RESP_OKAY);
    `CHK("out_pad", 1'b1, pad_ctrl.out[0])
    `CHK("oe_n0", 1'b0, pad_ctrl.oe_n[0])
    rd(OFF_CFG_BASE, CFG_RESET | 32'h00000001, RESP_OKAY);
    wr(OFF_DIRCLR, 32'h00000001, RESP_OKAY);
    wr(OFF_OUT, 32'h00000000, RESP_OKAY);
    rd(OFF_CFG_BASE, CFG_RESET, RESP_OKAY);
    wr(OFF_IN, 32'hFFFFFFFF, RESP_OKAY);
    rd(OFF_IN, 32'h00000000, RESP_OKAY);
    for (k = 0; k < 4; k++)
    begin
      p = $unsigned($random(seed)) % NUM_PINS;
      bit_p = 32'h1 << p;
      ext_en[p] <= 1'b1;
      ext_lvl[p] <= k[0];
      cyc(3);
      wr(OFF_CFG_BASE + 12'(4 * p), {14'h0, k[0] ? SENSE_LOW : SENSE_HIGH, 16'h0}, RESP_OKAY);
      cyc(3);
      `CHK("pd_idle", 1'b0, pin_detect[p])
      ext_lvl[p] <= !k[0];
      cyc(4);
      `CHK("pd_hit", 1'b1, pin_detect[p])
      `CHK("port", 1'b1, port_detect)
      m_latch[p] = 1'b1;
      rd(OFF_LATCH, m_latch, RESP_OKAY);
      wr(OFF_LATCH, bit_p, RESP_OKAY);
      `CHK("gap", 1'b0, ld_b)
      cyc(1);
      `CHK("ldet", 1'b1, latched_detect)
      rd(OFF_LATCH, m_latch, RESP_OKAY);
      ext_lvl[p] <= k[0];
      cyc(4);
      rd(OFF_LATCH, m_latch, RESP_OKAY);
      wr(OFF_LATCH, 32'h0, RESP_OKAY);
      rd(OFF_LATCH, m_latch, RESP_OKAY);
      wr(OFF_LATCH, bit_p, RESP_OKAY);
      m_latch[p] = 1'b0;
      rd(OFF_LATCH, m_latch, RESP_OKAY);
      `CHK("ldet_low", 1'b0, latched_detect)
      wr(OFF_CFG_BASE + 12'(4 * p), CFG_RESET, RESP_OKAY);
    end
    ext_en[5] <= 1'b1;
    ext_lvl[5] <= 1'b1;
    wr(OFF_CFG_BASE + 12'h014, 32'h00020002, RESP_OKAY);
    cyc(3);
    `CHK("pd_disc", 1'b0, pin_detect[5])
    rd(OFF_IN, 32'h0, RESP_OKAY);
    wr(OFF_CFG_BASE + 12'h014, 32'h0, RESP_OKAY);
    rd(OFF_IN, 32'h20, RESP_OKAY);
    `CHK("pd_sense_off", 1'b0, pin_detect[5])
    wr(OFF_CFG_BASE + 12'h014, 32'h00020000, RESP_OKAY);
    `CHK("pd_now", 1'b1, pin_detect[5])
    @(posedge aclk);
    `CHK("event", 1'b1, port_sense_event)
    `CHK("periph_in", 32'h20, periph_pin_in)
    m_latch[5] = 1'b1;
    power_off <= 1'b1;
    ext_lvl[5] <= 1'b0;
    @(posedge aclk);
    `CHK("pd_raw_lo", 1'b0, pin_detect[5])
    ext_lvl[5] <= 1'b1;
    @(posedge aclk);
    `CHK("pd_raw_hi", 1'b1, pin_detect[5])
    `CHK("port_raw", 1'b1, port_detect)
    power_off <= 1'b0;
    wr(OFF_DETECT_SRC, 32'h1, RESP_OKAY);
    rd(OFF_DETECT_SRC, 32'h1, RESP_OKAY);
    ext_lvl[5] <= 1'b0;
    cyc(4);
    rd(OFF_LATCH, m_latch, RESP_OKAY);
    `CHK("port_ld", 1'b1, port_detect)
    wr(OFF_LATCH, m_latch, RESP_OKAY);
    `CHK("port_clr", 1'b0, port_detect)
    pin_override.en[3] <= 1'b1;
    pin_override.out[3] <= 1'b1;
    pin_override.drive_en[3] <= 1'b1;
    pin_override.input_en[3] <= 1'b1;
    cyc(4);
    `CHK("ovr_out", 1'b1, pad_ctrl.out[3])
    `CHK("ovr_oe", 1'b0, pad_ctrl.oe_n[3])
    `CHK("ovr_in", 1'b1, periph_pin_in[3])
    tally_and_finish();
  end
endmodule
`default_nettype wire
